// >>> rtl/rop_engine.v
// Raster-operation datapath of a 16-bit-per-pixel 2D drawing engine.
// Assumes the frame-buffer side supplies one source and destination pixel per
// valid cycle and accepts one result per cycle; coordinates come from a walker.
// Destination pixels are 16-bit 565, source pixels 565, 8888, 1555 or 4444; the register port is word indexed.
// Operation
// (RULE1) Only 16-bit destination pixels are produced by any function.
// (RULE2) Six functions: blit, colour expansion, keyed, line, stretch, alpha blend.
// (RULE3) Alpha from a constant or from 8888, 1555, 4444 source pixels.
// (RULE4) Coordinates optionally rotated 90, -90, 180, mirrored or flipped.
// (RULE5) One destination pixel completed every engine clock.
// (RULE6) Blit and expansion use an 8-bit ternary raster code.
// (RULE7) Line drawing uses a binary code without source operand.
// (RULE8) Line pattern from line style, destination from destination bitmap.
// (RULE9) Operands combined only with bitwise AND, NOT, OR, XOR.
// (RULE10) Code bit index is P:S:D with pattern most significant.
// (RULE11) Pattern OR source is FC, all three ORed is FE.
// (RULE12) Solid fill is blit with code F0 using foreground colour.
// (RULE13) Source copy is blit with code CC copying source unchanged.
// (RULE14) Same function applied independently to all 16 bit positions.
`timescale 1ns/1ps
`include "rop_consts.vh"
module rop_engine
(
    input  wire        core_clk,
    input  wire        nrst,
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdData,
    input  wire        pixValid,
    input  wire [31:0] srcPixel,
    input  wire [15:0] dstPixel,
    input  wire [15:0] patPixel,
    input  wire        monoBit,
    input  wire [10:0] pixX,
    input  wire [10:0] pixY,
    input  wire [10:0] areaWidth,
    input  wire [10:0] areaHeight,
    output reg         outValid,
    output reg  [15:0] outPixel,
    output reg  [10:0] outX,
    output reg  [10:0] outY,
    output reg         outWrite,
    output wire        needDstRead
);
    // Programmable state, pixel count and line-style position
    reg  [31:0] ctrl;
    reg  [15:0] fgColor;
    reg  [15:0] bgColor;
    reg  [15:0] lineStyle;
    reg  [31:0] srcKey;
    reg  [15:0] dstKey;
    reg  [7:0]  constAlpha;
    reg  [31:0] pixCount;
    reg  [3:0]  stylePos;

    wire [7:0]  code     = ctrl[`ROP_CTRL_CODE_MSB:`ROP_CTRL_CODE_LSB];
    wire [2:0]  func     = ctrl[`ROP_CTRL_FUNC_MSB:`ROP_CTRL_FUNC_LSB];
    wire [2:0]  xform    = ctrl[`ROP_CTRL_XFORM_MSB:`ROP_CTRL_XFORM_LSB];
    wire [1:0]  alphaFmt = ctrl[`ROP_CTRL_AFMT_MSB:`ROP_CTRL_AFMT_LSB];
    wire [3:0]  keyCode  = ctrl[`ROP_CTRL_TKEY_MSB:`ROP_CTRL_TKEY_LSB];

    // Register writes
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl       <= `ROP_CTRL_RESET;
            fgColor    <= 16'h0000;
            bgColor    <= 16'h0000;
            lineStyle  <= 16'hffff;
            srcKey     <= 32'h0000_0000;
            dstKey     <= 16'h0000;
            constAlpha <= 8'hff;
        end
        else if (regWrite)
        begin
            // Unmapped offsets leave every register as it was
            case (regAddr)
                `ROP_REG_CTRL:      ctrl       <= regWrData;
                `ROP_REG_FGCOLOR:   fgColor    <= regWrData[15:0];
                `ROP_REG_BGCOLOR:   bgColor    <= regWrData[15:0];
                `ROP_REG_LINESTYLE: lineStyle  <= regWrData[15:0];
                `ROP_REG_KEYS:      srcKey     <= regWrData;
                `ROP_REG_DSTKEY:    dstKey     <= regWrData[15:0];
                `ROP_REG_ALPHA:     constAlpha <= regWrData[7:0];
                default:            ctrl       <= ctrl;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero for unmapped offsets
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            regRdData <= 32'h0000_0000;
        else if (regRead)
        begin
            case (regAddr)
                `ROP_REG_CTRL:      regRdData <= ctrl;
                `ROP_REG_FGCOLOR:   regRdData <= {16'h0000, fgColor};
                `ROP_REG_BGCOLOR:   regRdData <= {16'h0000, bgColor};
                `ROP_REG_LINESTYLE: regRdData <= {16'h0000, lineStyle};
                `ROP_REG_KEYS:      regRdData <= srcKey;
                `ROP_REG_DSTKEY:    regRdData <= {16'h0000, dstKey};
                `ROP_REG_ALPHA:     regRdData <= {24'h000000, constAlpha};
                `ROP_REG_STATUS:    regRdData <= {28'h0000000, stylePos};
                `ROP_REG_COUNT:     regRdData <= pixCount;
                default:            regRdData <= 32'h0000_0000;
            endcase
        end
        else
            regRdData <= 32'h0000_0000;
    end

    // Source pixel reduced to 16 bits 565 for every function
    reg [15:0] src16;
    reg [7:0]  pixAlpha;
    always @*
    begin
        src16    = srcPixel[15:0];
        pixAlpha = constAlpha;
        case (alphaFmt)
            // 8888: alpha in the top byte, colour cut to 565
            `ROP_AF_8888:
            begin
                src16    = {srcPixel[23:19], srcPixel[15:10], srcPixel[7:3]};
                pixAlpha = srcPixel[31:24];                           // [RULE3]
            end
            // 1555: one alpha bit spread over a full byte
            `ROP_AF_1555:
            begin
                src16    = {srcPixel[14:10], srcPixel[9:5], srcPixel[9], srcPixel[4:0]};
                pixAlpha = {8{srcPixel[15]}};                         // [RULE3]
            end
            // 4444: nibbles widened by repeating their top bits
            `ROP_AF_4444:
            begin
                src16    = {srcPixel[11:8], srcPixel[11], srcPixel[7:4], srcPixel[7:6],
                            srcPixel[3:0], srcPixel[3]};
                pixAlpha = {srcPixel[15:12], srcPixel[15:12]};        // [RULE3]
            end
            // Constant alpha with a 565 source
            default:
            begin
                src16    = srcPixel[15:0];
                pixAlpha = constAlpha;                                // [RULE3]
            end
        endcase
    end

    // Binary line code spread over both source halves, so S drops out
    wire [7:0] lineCode = {code[3:2], code[3:2], code[1:0], code[1:0]};   // [RULE7]

    // Pattern and source operands per function
    wire       styleBit = lineStyle[stylePos];
    reg [15:0] opPat;
    reg [15:0] opSrc;
    reg [7:0]  effCode;
    always @*
    begin
        opPat   = patPixel;
        opSrc   = src16;
        effCode = code;                                               // [RULE6]
        case (func)
            // Colour expansion: mono bit picks foreground or background
            `ROP_FN_EXPAND:
                opSrc = monoBit ? fgColor : bgColor;
            `ROP_FN_LINE:
            begin
                opPat   = styleBit ? fgColor : bgColor;               // [RULE8]
                opSrc   = 16'h0000;
                // Binary code: source index ignored
                effCode = lineCode;                                   // [RULE7]
            end
            default:
            begin
                // Solid fill with F0 takes the foreground colour as pattern
                if (code == `ROP_CODE_FILL && func == `ROP_FN_BLIT)
                    opPat = fgColor;                                  // [RULE12]
            end
        endcase
    end

    // Bitwise raster operation over all 16 bits
    wire [15:0] ropOut;
    genvar gi;
    generate
        // One lookup slice per pixel bit
        for (gi = 0; gi < `ROP_PIX_W; gi = gi + 1)
        begin : gBit
            rop_bit_lut uBit
            (
                .code   (effCode),
                .patBit (opPat[gi]),
                .srcBit (opSrc[gi]),
                .dstBit (dstPixel[gi]),
                .outBit (ropOut[gi])
            );                                  // [RULE9] [RULE10] [RULE14]
        end
    endgenerate
    // Well-known codes need no special case in the lookup: F0 passes the pattern, CC the
    // source, FC is pattern OR source and FE ORs all three   [RULE11] [RULE13]

    // Keyed transfer: table bit picked by the complement of both key hits,
    // so bit 0 is taken when both keys match and bit 3 when neither does
    wire       srcHit  = (src16 == srcKey[15:0]);
    wire       dstHit  = (dstPixel == dstKey);
    wire [1:0] keyIdx  = {~dstHit, ~srcHit};
    wire       takeSrc = keyCode[keyIdx];                             // [RULE2]

    // Destination fetch is skipped when the table ignores the destination hit
    assign needDstRead = (func == `ROP_FN_KEYED) ?
                         (keyCode[3:2] != keyCode[1:0]) : 1'b1;

    // Alpha blend per channel; the shift by 8 plus the carried top bit stands
    // in for the division by 255; at both ends of the alpha range it is exact only for channel values 0 and 129 to 255
    function [7:0] blendCh;
        input [7:0] s;
        input [7:0] d;
        input [7:0] a;
        reg   [16:0] sum;
        begin
            // Both products kept at the full width of the sum
            sum     = s * a + d * (8'hff - a);
            blendCh = sum[15:8] + {7'h00, sum[15]};
        end
    endfunction
    // Source channels widened to 8 bits by repeating their top bits
    wire [7:0] sR = {src16[15:11], src16[15:13]};
    wire [7:0] sG = {src16[10:5],  src16[10:9]};
    wire [7:0] sB = {src16[4:0],   src16[4:2]};
    // Destination channels widened the same way
    wire [7:0] dR = {dstPixel[15:11], dstPixel[15:13]};
    wire [7:0] dG = {dstPixel[10:5],  dstPixel[10:9]};
    wire [7:0] dB = {dstPixel[4:0],   dstPixel[4:2]};
    // Blended channels, cut back to 565 at the result select
    wire [7:0] bR = blendCh(sR, dR, pixAlpha);
    wire [7:0] bG = blendCh(sG, dG, pixAlpha);
    wire [7:0] bB = blendCh(sB, dB, pixAlpha);

    // Result select per function, always 16 bits
    reg [15:0] next_pixel;
    always @*
    begin
        case (func)
            `ROP_FN_KEYED:   next_pixel = takeSrc ? src16 : dstPixel;
            `ROP_FN_STRETCH: next_pixel = src16;
            `ROP_FN_ALPHA:   next_pixel = {bR[7:3], bG[7:2], bB[7:3]};
            default:         next_pixel = ropOut;
        endcase                                                       // [RULE1] [RULE2]
    end

    // Coordinate transform
    reg  [10:0] next_x;
    reg  [10:0] next_y;
    // Largest column and row of the area, the axes of mirror and flip
    wire [10:0] wMax = areaWidth  - 11'h001;
    wire [10:0] hMax = areaHeight - 11'h001;
    // 90-degree rotations swap the axes, 180 reflects both; mirror and flip reflect one of them
    always @*
    begin
        case (xform)
            `ROP_XF_ROT90:
            begin
                next_x = hMax - pixY;
                next_y = pixX;
            end
            `ROP_XF_ROTM90:
            begin
                next_x = pixY;
                next_y = wMax - pixX;
            end
            `ROP_XF_ROT180:
            begin
                next_x = wMax - pixX;
                next_y = hMax - pixY;
            end
            `ROP_XF_MIRROR:
            begin
                next_x = wMax - pixX;
                next_y = pixY;
            end
            `ROP_XF_FLIP:
            begin
                next_x = pixX;
                next_y = hMax - pixY;
            end
            default:
            begin
                next_x = pixX;
                next_y = pixY;
            end
        endcase                                                       // [RULE4]
    end

    // One pixel out per clock with its transformed position
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outValid <= 1'b0;
            outWrite <= 1'b0;
            outPixel <= 16'h0000;
            outX     <= 11'h000;
            outY     <= 11'h000;
        end
        else
        begin
            outValid <= pixValid;                                     // [RULE5]
            outWrite <= pixValid;
            // Pixel and position hold until the next pixel
            if (pixValid)
            begin
                outPixel <= next_pixel;
                outX     <= next_x;
                outY     <= next_y;
            end
        end
    end

    // Count of pixels taken since reset
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pixCount <= 32'h0000_0000;
        else if (pixValid)
            pixCount <= pixCount + 32'h0000_0001;
    end

    // Line-style position: restarts on a control write, steps per line pixel
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            stylePos <= 4'h0;
        else if (regWrite && regAddr == `ROP_REG_CTRL)
            stylePos <= 4'h0;
        else if (pixValid && func == `ROP_FN_LINE)
            stylePos <= stylePos + 4'h1;                              // [RULE8]
    end
endmodule // rop_engine

// >>> rtl/rop_consts.vh
// Constants of the raster-operation datapath: register offsets, fields, codes.
// Assumes inclusion by bare name from the rop design files.
`ifndef ROP_CONSTS_VH
`define ROP_CONSTS_VH
// Register offsets (word index on the plain register port)
`define ROP_REG_CTRL      4'h0
`define ROP_REG_FGCOLOR   4'h1
`define ROP_REG_BGCOLOR   4'h2
`define ROP_REG_LINESTYLE 4'h3
`define ROP_REG_KEYS      4'h4
`define ROP_REG_DSTKEY    4'h5
`define ROP_REG_ALPHA     4'h6
`define ROP_REG_STATUS    4'h7
`define ROP_REG_COUNT     4'h8
// Control register fields
`define ROP_CTRL_CODE_LSB  0
`define ROP_CTRL_CODE_MSB  7
`define ROP_CTRL_FUNC_LSB  8
`define ROP_CTRL_FUNC_MSB  10
`define ROP_CTRL_XFORM_LSB 11
`define ROP_CTRL_XFORM_MSB 13
`define ROP_CTRL_AFMT_LSB  14
`define ROP_CTRL_AFMT_MSB  15
`define ROP_CTRL_TKEY_LSB  16
`define ROP_CTRL_TKEY_MSB  19
`define ROP_CTRL_RESET     32'h0000_00cc
// Drawing functions
`define ROP_FN_BLIT    3'h0
`define ROP_FN_EXPAND  3'h1
`define ROP_FN_KEYED   3'h2
`define ROP_FN_LINE    3'h3
`define ROP_FN_STRETCH 3'h4
`define ROP_FN_ALPHA   3'h5
// Coordinate transforms
`define ROP_XF_NONE    3'h0
`define ROP_XF_ROT90   3'h1
`define ROP_XF_ROTM90  3'h2
`define ROP_XF_ROT180  3'h3
`define ROP_XF_MIRROR  3'h4
`define ROP_XF_FLIP    3'h5
// Alpha sources
`define ROP_AF_CONST   2'h0
`define ROP_AF_8888    2'h1
`define ROP_AF_1555    2'h2
`define ROP_AF_4444    2'h3
// Well-known ternary codes
`define ROP_CODE_FILL      8'hf0
`define ROP_CODE_COPY      8'hcc
`define ROP_CODE_PAT_OR_SRC 8'hfc
`define ROP_CODE_DPS_OR    8'hfe
`define ROP_PIX_W          16
`endif

// >>> rtl/rop_bit_lut.v
// One bit slice of the raster-operation lookup.
// Assumes the code is stable for the cycle the operands are presented.
`timescale 1ns/1ps
module rop_bit_lut
(
    input  wire [7:0] code,
    input  wire       patBit,
    input  wire       srcBit,
    input  wire       dstBit,
    output wire       outBit
);
    // Index P:S:D selects the code bit, P most significant
    assign outBit = code[{patBit, srcBit, dstBit}];
endmodule // rop_bit_lut

// >>> tb/rop_engine_chk.sv
// Port checker of the raster-op engine.
// Assumes bind to rop_engine; shadows ctrl and fg writes itself.
`timescale 1ns/1ps
`include "rop_consts.vh"
module rop_engine_chk
(
    input wire        core_clk,
    input wire        nrst,
    input wire [3:0]  regAddr,
    input wire [31:0] regWrData,
    input wire        regWrite,
    input wire        regRead,
    input wire [31:0] regRdData,
    input wire        pixValid,
    input wire [31:0] srcPixel,
    input wire [15:0] dstPixel,
    input wire [15:0] patPixel,
    input wire        monoBit,
    input wire        outValid,
    input wire        outWrite,
    input wire [15:0] outPixel,
    input wire        needDstRead
);
    reg  [31:0] ctrl;
    reg  [15:0] fg;
    wire [7:0]  code = ctrl[7:0];
    wire [2:0]  fn   = ctrl[10:8];
    wire        blit = pixValid && fn == `ROP_FN_BLIT;
    // Per-bit lookup of the code
    function [15:0] lut(input [7:0] c, input [15:0] p, input [15:0] s, input [15:0] d);
        integer b;
        begin
            for (b = 0; b < 16; b = b + 1)
                lut[b] = c[{p[b], s[b], d[b]}];
        end
    endfunction
    // Shadow of control and foreground writes
    always @(posedge core_clk or negedge nrst)
        if (!nrst)
        begin
            ctrl <= `ROP_CTRL_RESET;
            fg   <= 16'h0;
        end
        else if (regWrite)
        begin
            if (regAddr == `ROP_REG_CTRL)
                ctrl <= regWrData;
            if (regAddr == `ROP_REG_FGCOLOR)
                fg <= regWrData[15:0];
        end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_valid; pixValid |=> outValid && outWrite; endproperty
    a_valid: assert property (p_valid) else $error("no result after pixel");
    property p_rd_idle; !regRead |=> regRdData == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_hold; !pixValid |=> $stable(outPixel); endproperty
    a_hold: assert property (p_hold) else $error("pixel changed while idle");
    property p_ternary_raster_code;
        blit && code != `ROP_CODE_FILL |=> outPixel ==
            lut($past(code), $past(patPixel), $past(srcPixel[15:0]), $past(dstPixel));
    endproperty
    a_ternary_raster_code: assert property (p_ternary_raster_code) else $error("ternary result wrong");
    property p_copy; blit && code == `ROP_CODE_COPY |=> outPixel == $past(srcPixel[15:0]);
    endproperty
    a_copy: assert property (p_copy) else $error("copy result wrong");
    property p_fill; blit && code == `ROP_CODE_FILL |=> outPixel == $past(fg); endproperty
    a_fill: assert property (p_fill) else $error("fill result wrong");
    property p_or; blit && code == `ROP_CODE_PAT_OR_SRC |=>
        outPixel == ($past(patPixel) | $past(srcPixel[15:0])); endproperty
    a_or: assert property (p_or) else $error("or result wrong");
    property p_line; pixValid && fn == `ROP_FN_LINE && code[3:0] == 4'ha |=>
        outPixel == $past(dstPixel); endproperty
    a_line: assert property (p_line) else $error("line result wrong");
    property p_key; fn == `ROP_FN_KEYED && ctrl[19:16] == 4'hf |-> !needDstRead; endproperty
    a_key: assert property (p_key) else $error("needless destination read");
    c_fill: cover property (blit && code == `ROP_CODE_FILL);
    c_line: cover property (pixValid && fn == `ROP_FN_LINE);
    c_burst: cover property (pixValid [*3]);
endmodule // rop_engine_chk
bind rop_engine rop_engine_chk chk (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .pixValid(pixValid), .srcPixel(srcPixel), .dstPixel(dstPixel), .patPixel(patPixel),
    .monoBit(monoBit), .outValid(outValid), .outWrite(outWrite), .outPixel(outPixel),
    .needDstRead(needDstRead));

// >>> tb/rop_fb_model.sv
// Frame-buffer model: source and destination pixel per slot.
// Assumes the bench loads slots and selects one per pixel.
`timescale 1ns/1ps
module rop_fb_model
(
    input  wire        core_clk,
    input  wire [2:0]  slot,
    input  wire        outWrite,
    input  wire [15:0] outPixel,
    output wire [31:0] srcPixel,
    output wire [15:0] dstPixel
);
    reg [31:0] srcMem [0:7];
    reg [15:0] dstMem [0:7];
    reg [2:0]  lastSlot;
    integer    k;
    // Empty memory at start
    initial
        for (k = 0; k < 8; k = k + 1)
        begin
            srcMem[k] = 32'h0;
            dstMem[k] = 16'h0;
        end
    // Read ports follow the selected slot
    assign srcPixel = srcMem[slot];
    assign dstPixel = dstMem[slot];
    // Result written back over its destination
    always @(posedge core_clk)
    begin
        lastSlot <= slot;
        if (outWrite)
            dstMem[lastSlot] <= outPixel;
    end
endmodule // rop_fb_model

// >>> tb/rop_engine_tb.sv
// Testbench of the raster-op engine.
// Assumes rop_engine, its bound checker and the frame-buffer model.
`timescale 1ns/1ps
`include "rop_consts.vh"
module rop_engine_tb;
    reg  [3:0]  regAddr;
    reg  [31:0] regWrData;
    reg  [15:0] patPixel;
    reg  [10:0] pixX;
    reg  [2:0]  slot;
    reg         core_clk, nrst, regWrite, regRead, pixValid, monoBit;
    wire [31:0] regRdData, srcPixel;
    wire [15:0] dstPixel, outPixel;
    wire        outValid, outWrite, needDstRead;
    wire [10:0] outX, outY;
    reg  [10:0] ex, ey;
    integer     error_cnt, num_checks, i;
    localparam [15:0] PV = 16'hff00, SV = 16'hf0f0, DV = 16'hcccc;
    // Clock of 4 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    rop_engine dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .pixValid(pixValid), .srcPixel(srcPixel),
        .dstPixel(dstPixel), .patPixel(patPixel), .monoBit(monoBit), .pixX(pixX),
        .pixY(11'h0), .areaWidth(11'h10), .areaHeight(11'h10), .outValid(outValid),
        .outPixel(outPixel), .outX(outX), .outY(outY), .outWrite(outWrite),
        .needDstRead(needDstRead));
    rop_fb_model fb (.core_clk(core_clk), .slot(slot), .outWrite(outWrite),
        .outPixel(outPixel), .srcPixel(srcPixel), .dstPixel(dstPixel));
    // Reference lookup: code bit chosen by P:S:D per pixel bit
    function [15:0] ref_lut(input [7:0] c, input [15:0] p, input [15:0] s, input [15:0] d);
        integer b;
        begin
            for (b = 0; b < 16; b = b + 1)
                ref_lut[b] = c[{p[b], s[b], d[b]}];
        end
    endfunction
    // Compare and count
    task check(input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    end
    endtask
    task rd(input [3:0] a, input [31:0] exp);
    begin
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 check(regRdData, exp);
    end
    endtask
    // One pixel through a fresh slot; result settled on return
    task px(input [31:0] s, input [15:0] d, input [15:0] p, input m);
    begin
        @(posedge core_clk);
        fb.srcMem[slot + 3'h1] = s;
        fb.dstMem[slot + 3'h1] = d;
        slot <= slot + 3'h1;
        pixValid <= 1'b1;
        patPixel <= p;
        monoBit <= m;
        pixX <= pixX + 11'h1;
        @(posedge core_clk);
        pixValid <= 1'b0;
        #1 check({31'h0, outValid}, 32'h1);
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Watchdog
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    // Main sequence
    initial
    begin
        error_cnt = 0; num_checks = 0; nrst = 0; regAddr = 0; regWrData = 0;
        regWrite = 0; regRead = 0; pixValid = 0; patPixel = 0; monoBit = 0;
        pixX = 0; slot = 0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`ROP_REG_CTRL, `ROP_CTRL_RESET);
        rd(`ROP_REG_LINESTYLE, 32'hffff);
        rd(`ROP_REG_ALPHA, 32'hff);
        rd(4'hc, 32'h0);
        wr(`ROP_REG_FGCOLOR, {16'h0, PV});
        rd(`ROP_REG_FGCOLOR, {16'h0, PV});
        $display("test registers done");
        for (i = 0; i < 256; i = i + 1)
        begin
            wr(`ROP_REG_CTRL, i);
            px({16'h0, SV}, DV, PV, 1'b0);
            check(outPixel, ref_lut(i[7:0], PV, SV, DV));
        end
        wr(`ROP_REG_FGCOLOR, 32'h1234);
        wr(`ROP_REG_BGCOLOR, 32'h5678);
        wr(`ROP_REG_CTRL, `ROP_CODE_FILL);
        px(32'h0, DV, PV, 1'b0);
        check(outPixel, 32'h1234);
        wr(`ROP_REG_CTRL, 32'h1cc);
        px(32'h0, DV, PV, 1'b1);
        check(outPixel, 32'h1234);
        px(32'h0, DV, PV, 1'b0);
        check(outPixel, 32'h5678);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(`ROP_REG_CTRL, (i << 11) | 32'hcc);
            px({16'h0, SV}, DV, PV, 1'b0);
            check(outPixel, SV);
            ex = (i == 1) ? 11'hf : (i == 2) ? 11'h0 : (i == 3 || i == 4) ? 11'hf - pixX : pixX;
            ey = (i == 1) ? pixX : (i == 2) ? 11'hf - pixX : (i == 3 || i == 5) ? 11'hf : 11'h0;
            check(outX, ex);
            check(outY, ey);
        end
        $display("test blit done");
        for (i = 0; i < 16; i = i + 1)
        begin
            wr(`ROP_REG_CTRL, 32'h300 | i);
            px(32'h0, DV, PV, 1'b0);
            check(outPixel, ref_lut({i[3], i[2], i[3], i[2], i[1], i[0], i[1], i[0]},
                16'h1234, 16'h0, DV));
        end
        rd(`ROP_REG_STATUS, 32'h1);
        $display("test line done");
        for (i = 0; i < 16; i = i + 1)
        begin
            wr(`ROP_REG_CTRL, 32'h200 | (i << 16));
            check({31'h0, needDstRead}, (i % 5) != 0);
            if (i == 0 || i == 15)
            begin
                px({16'h0, SV}, DV, PV, 1'b0);
                check(outPixel, i == 0 ? DV : SV);
            end
        end
        $display("test keyed done");
        wr(`ROP_REG_CTRL, 32'h500);
        px(32'hf800, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'hf800);
        wr(`ROP_REG_ALPHA, 32'h0);
        px(32'hf800, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'h07ff);
        wr(`ROP_REG_CTRL, 32'h4500);
        px(32'hffff0000, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'hf800);
        wr(`ROP_REG_CTRL, 32'h8500);
        px(32'h7c00, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'h07ff);
        wr(`ROP_REG_CTRL, 32'hc500);
        px(32'hf000, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'h0);
        wr(`ROP_REG_CTRL, 32'h400);
        px(32'habcd, 16'h07ff, PV, 1'b0);
        check(outPixel, 32'habcd);
        $display("test alpha done");
        wr(`ROP_REG_CTRL, `ROP_CODE_COPY);
        for (i = 0; i < 4; i = i + 1)
            fb.srcMem[i] = 32'h100 + i;
        @(posedge core_clk);
        pixValid <= 1'b1;
        slot <= 3'h0;
        for (i = 1; i < 5; i = i + 1)
        begin
            @(posedge core_clk);
            if (i < 4)
                slot <= i[2:0];
            else
                pixValid <= 1'b0;
            #1 check(outPixel, 32'h100 + i - 1);
        end
        $display("test burst done");
        rd(`ROP_REG_COUNT, 32'h125);
        report_and_stop;
    end
endmodule // rop_engine_tb
